/* File: nfb_bridge.sv */
// Top of the NAND flash port bridge: held lines, strobes, read data.
// Assumes the host keeps each access stable while it lasts.
`timescale 1ns/1ns
module nfb_bridge
  import nfb_pkg::*;
#(
  parameter int ADDR_W = 16,
  parameter logic [ADDR_W-1:0] BASE = '0,
  parameter int RB_N = 1
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // Host bus
  input  wire logic              host_select_n,
  input  wire logic              host_rd_n,
  input  wire logic              host_wr_n,
  input  wire logic [ADDR_W-1:0] host_addr,
  input  wire logic [7:0]        host_wdata,
  output logic      [7:0]        host_rdata,
  output logic                   host_rdata_oe_n,
  // Ready output to host
  output logic                   ready,
  output logic                   ready_oe_n,
  // Flash side
  input  wire logic [7:0]        flash_io_in,
  output logic      [7:0]        flash_io_out,
  output logic                   flash_io_oe_n,
  output logic                   address_latch,
  output logic                   command_latch,
  output logic                   read_strobe_n,
  output logic                   write_strobe_n,
  output logic                   spare_enable_n,
  output logic                   write_protect_n,
  output logic                   flash_select_out_n,
  input  wire logic [RB_N-1:0]   ready_busy_n
);

  typedef struct packed {
    nfb_ctrl_t ctrl;
  } nfb_state_t;

  nfb_access_t acc;
  nfb_state_t  s_q;
  nfb_state_t  s_d;
  logic        rd0;
  logic        rdf;
  logic        host_hit;
  logic        host_rd;
  logic        host_wr;

  // ============================================================
  // Decoder.
  nfb_decode #(
    .ADDR_W (ADDR_W),
    .BASE   (BASE)
  ) u_dec (
    .host_select_n (host_select_n),
    .host_rd_n     (host_rd_n),
    .host_wr_n     (host_wr_n),
    .host_addr     (host_addr),
    .acc           (acc)
  );

  // ============================================================
  // Held control lines.
  always_comb begin
    s_d = s_q;
    if (acc.wr) begin
      case (acc.port)
        NFB_ADDRESS_LATCH_SET:   s_d.ctrl.addr_latch         = 1'b1;
        NFB_ADDRESS_LATCH_CLEAR: s_d.ctrl.addr_latch         = 1'b0;
        NFB_SPARE_ENABLE_SET:    s_d.ctrl.spare_enable_n     = 1'b0;
        NFB_SPARE_ENABLE_CLEAR:  s_d.ctrl.spare_enable_n     = 1'b1;
        NFB_WRITE_PROTECT_SET:   s_d.ctrl.write_protect_n    = 1'b0;
        NFB_WRITE_PROTECT_CLEAR: s_d.ctrl.write_protect_n    = 1'b1;
        NFB_FLASH_SELECT_SET:    s_d.ctrl.flash_select_out_n = 1'b0;
        NFB_FLASH_SELECT_CLEAR:  s_d.ctrl.flash_select_out_n = 1'b1;
        default: s_d = s_q;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_q.ctrl.addr_latch         <= NFB_RST_ADDR_LATCH;
      s_q.ctrl.spare_enable_n     <= NFB_RST_SPARE_N;
      s_q.ctrl.write_protect_n    <= NFB_RST_PROTECT_N;
      s_q.ctrl.flash_select_out_n <= NFB_RST_SELECT_N;
    end else begin
      s_q <= s_d;
    end
  end

  // ============================================================
  // Strobes and data paths, combinational with the access.
  always_comb begin
    rd0 = acc.rd && acc.port == NFB_FLASH_DATA_ADDRESS_PORT;
    rdf = acc.rd && acc.port == NFB_READY_BUSY_STATUS;
    address_latch      = s_q.ctrl.addr_latch;
    spare_enable_n     = s_q.ctrl.spare_enable_n;
    write_protect_n    = s_q.ctrl.write_protect_n;
    flash_select_out_n = s_q.ctrl.flash_select_out_n;
    command_latch  = !reset && (acc.rd || acc.wr) &&
                     acc.port == NFB_FLASH_COMMAND_PORT;
    read_strobe_n  = reset || !rd0;
    write_strobe_n = reset || !(acc.wr &&
                     (acc.port == NFB_FLASH_DATA_ADDRESS_PORT ||
                      acc.port == NFB_FLASH_COMMAND_PORT));
    flash_io_out   = host_wdata;
    flash_io_oe_n  = write_strobe_n;
    host_rdata     = 8'h00;
    if (rd0) begin
      host_rdata = flash_io_in;
    end else if (rdf) begin
      host_rdata = 8'(ready_busy_n);
    end
    host_rdata_oe_n = reset || !(rd0 || rdf);
    ready       = &ready_busy_n;
    ready_oe_n  = reset || !rdf;
  end

  // ============================================================
  // Host access seen straight from the pins, for the checks only.
  always_comb begin
    host_hit = !host_select_n &&
               host_addr[ADDR_W-1:4] == BASE[ADDR_W-1:4];
    host_rd  = host_hit && !host_rd_n;
    host_wr  = host_hit && !host_wr_n && host_rd_n;
  end

  // ============================================================
  // Sequences.
  sequence port_write_s(logic [3:0] p);
    host_wr && host_addr[3:0] == p;
  endsequence

  sequence addr_byte_s;
    address_latch && !command_latch && !write_strobe_n;
  endsequence

  sequence cmd_byte_s;
    !address_latch && command_latch && !write_strobe_n;
  endsequence

  // ============================================================
  // Checks.
  cmd_latch_a: assert property (@(posedge clk) disable iff (reset)
    command_latch == ((host_rd || host_wr) &&
                      host_addr[3:0] == NFB_FLASH_COMMAND_PORT))
    else $error("Command latch wrong.");
  addr_phase_a: assert property (@(posedge clk) disable iff (reset)
    port_write_s(NFB_ADDRESS_LATCH_SET) ##1 !host_wr ##1
    port_write_s(NFB_FLASH_DATA_ADDRESS_PORT) |-> addr_byte_s)
    else $error("Address byte not marked.");
  cmd_phase_a: assert property (@(posedge clk) disable iff (reset)
    port_write_s(NFB_ADDRESS_LATCH_CLEAR) ##1 !host_wr ##1
    port_write_s(NFB_FLASH_COMMAND_PORT) |-> cmd_byte_s)
    else $error("Command byte not marked.");
  ale_hold_a: assert property (@(posedge clk) disable iff (reset)
    !(host_wr && host_addr[3:1] == 3'h1) |=> $stable(address_latch))
    else $error("Address latch moved.");
  spare_clr_a: assert property (@(posedge clk) disable iff (reset)
    port_write_s(NFB_SPARE_ENABLE_CLEAR) |=> spare_enable_n)
    else $error("Spare enable not cleared.");
  spare_hold_a: assert property (@(posedge clk) disable iff (reset)
    !(host_wr && host_addr[3:1] == 3'h2) |=> $stable(spare_enable_n))
    else $error("Spare enable moved.");
  protect_set_a: assert property (@(posedge clk) disable iff (reset)
    port_write_s(NFB_WRITE_PROTECT_SET) |=> !write_protect_n)
    else $error("Write protect not set.");
  protect_hold_a: assert property (@(posedge clk) disable iff (reset)
    !(host_wr && host_addr[3:1] == 3'h3) |=> $stable(write_protect_n))
    else $error("Write protect moved.");
  select_set_a: assert property (@(posedge clk) disable iff (reset)
    port_write_s(NFB_FLASH_SELECT_SET) |=> !flash_select_out_n)
    else $error("Flash select not set.");
  select_hold_a: assert property (@(posedge clk) disable iff (reset)
    !(host_wr && host_addr[3:1] == 3'h4) |=> $stable(flash_select_out_n))
    else $error("Flash select moved.");
  deselect_a: assert property (@(posedge clk) disable iff (reset)
    host_select_n |-> read_strobe_n && write_strobe_n && !command_latch &&
      ready_oe_n && host_rdata_oe_n)
    else $error("Activity while deselected.");
  base_miss_a: assert property (@(posedge clk) disable iff (reset)
    !host_hit |-> read_strobe_n && write_strobe_n && !command_latch &&
      ready_oe_n && host_rdata_oe_n)
    else $error("Activity outside the port range.");
  unused_quiet_a: assert property (@(posedge clk) disable iff (reset)
    host_hit && host_addr[3:0] inside {[4'hA:4'hE]} |->
      read_strobe_n && write_strobe_n && !command_latch &&
      ready_oe_n && host_rdata_oe_n)
    else $error("Unused port made a strobe.");
  rd_strobe_on_a: assert property (@(posedge clk) disable iff (reset)
    host_rd && host_addr[3:0] == NFB_FLASH_DATA_ADDRESS_PORT |->
      !read_strobe_n)
    else $error("Read strobe missing.");
  wr_strobe_on_a: assert property (@(posedge clk) disable iff (reset)
    host_wr && host_addr[3:1] == 3'h0 |-> !write_strobe_n)
    else $error("Write strobe missing.");
  one_strobe_a: assert property (@(posedge clk) disable iff (reset)
    !(!read_strobe_n && !write_strobe_n))
    else $error("Both strobes low.");
  io_drive_a: assert property (@(posedge clk) disable iff (reset)
    !write_strobe_n |-> !flash_io_oe_n && flash_io_out == host_wdata)
    else $error("Flash data not driven.");
  io_release_a: assert property (@(posedge clk) disable iff (reset)
    write_strobe_n |-> flash_io_oe_n)
    else $error("Flash data driven while idle.");
  flash_data_address_port_data_a: assert property (@(posedge clk) disable iff (reset)
    host_rd && host_addr[3:0] == NFB_FLASH_DATA_ADDRESS_PORT |->
      !host_rdata_oe_n && host_rdata == flash_io_in)
    else $error("Port 0 read data wrong.");
  ready_busy_status_data_a: assert property (@(posedge clk) disable iff (reset)
    host_rd && host_addr[3:0] == NFB_READY_BUSY_STATUS |->
      !host_rdata_oe_n && host_rdata == 8'(ready_busy_n))
    else $error("Port F read data wrong.");
  rdata_idle_a: assert property (@(posedge clk) disable iff (reset)
    host_rdata_oe_n |-> host_rdata == 8'h00)
    else $error("Read data not zero while idle.");
  ready_level_a: assert property (@(posedge clk) disable iff (reset)
    !ready_oe_n |-> ready == &ready_busy_n)
    else $error("Ready level wrong.");
  reset_quiet_a: assert property (@(posedge clk)
    reset |-> read_strobe_n && write_strobe_n && !command_latch &&
      ready_oe_n && host_rdata_oe_n && flash_io_oe_n)
    else $error("Strobes active in reset.");
  rd_strobe_a: assert property (@(posedge clk) disable iff (reset)
    !read_strobe_n |-> acc.rd && acc.port == 4'h0 && !host_select_n)
    else $error("Read strobe wrong.");
  wr_strobe_a: assert property (@(posedge clk) disable iff (reset)
    !write_strobe_n |-> acc.wr && acc.port[3:1] == 3'h0)
    else $error("Write strobe wrong.");
  ale_set_a: assert property (@(posedge clk) disable iff (reset)
    acc.wr && acc.port == 4'h2 |=> address_latch)
    else $error("Address latch not set.");
  ale_clr_a: assert property (@(posedge clk) disable iff (reset)
    acc.wr && acc.port == 4'h3 |=> !address_latch)
    else $error("Address latch not cleared.");
  spare_a: assert property (@(posedge clk) disable iff (reset)
    acc.wr && acc.port == 4'h4 |=> !spare_enable_n)
    else $error("Spare enable not set.");
  protect_a: assert property (@(posedge clk) disable iff (reset)
    acc.wr && acc.port == 4'h7 |=> write_protect_n)
    else $error("Write protect not cleared.");
  select_a: assert property (@(posedge clk) disable iff (reset)
    acc.wr && acc.port == 4'h9 |=> flash_select_out_n)
    else $error("Flash select not cleared.");
  unused_a: assert property (@(posedge clk) disable iff (reset)
    acc.wr && acc.port inside {[4'hA:4'hE]} |=> $stable(s_q))
    else $error("Unused port changed state.");
  ready_a: assert property (@(posedge clk) disable iff (reset)
    ready_oe_n == !(host_rd && host_addr[3:0] == NFB_READY_BUSY_STATUS))
    else $error("Ready enable wrong.");
  reset_a: assert property (@(posedge clk)
    $past(reset) && !reset |-> !address_latch && flash_select_out_n &&
      write_protect_n && spare_enable_n)
    else $error("Reset levels wrong.");

endmodule // nfb_bridge

/* File: nfb_pkg.sv */
// Package for the NAND flash port bridge: port map, reset levels, types.
// Assumes one 250 MHz clock and a synchronous active-high reset.
// ============================================================
// How it works
// - Decode only ports 0h to Fh above base.
// - Port 0 reads flash data, writes address/data.
// - Port 2 sets address latch, port 3 clears.
// - Port 4 enables spare area, port 5 blocks.
// - Port 6 protects writes, port 7 permits.
// - Port 8 selects flash, port 9 deselects.
// - Ports A to E do nothing at all.
// - Port F reads all ready/busy pins.
// - Decode only while host select is asserted.
// - Ready output driven only while read.
// - Command latch high during port 1 access.
// - Read strobe low during port 0 read.
// - Write strobe low on port 0/1 write.
// - Program: 80h, 32 data bytes, 10h.
// - Erase: 60h, two address cycles, D0h.
package nfb_pkg;

  // ============================================================
  // Port offsets.
  localparam logic [3:0] NFB_FLASH_DATA_ADDRESS_PORT = 4'h0;
  localparam logic [3:0] NFB_FLASH_COMMAND_PORT      = 4'h1;
  localparam logic [3:0] NFB_ADDRESS_LATCH_SET       = 4'h2;
  localparam logic [3:0] NFB_ADDRESS_LATCH_CLEAR     = 4'h3;
  localparam logic [3:0] NFB_SPARE_ENABLE_SET        = 4'h4;
  localparam logic [3:0] NFB_SPARE_ENABLE_CLEAR      = 4'h5;
  localparam logic [3:0] NFB_WRITE_PROTECT_SET       = 4'h6;
  localparam logic [3:0] NFB_WRITE_PROTECT_CLEAR     = 4'h7;
  localparam logic [3:0] NFB_FLASH_SELECT_SET        = 4'h8;
  localparam logic [3:0] NFB_FLASH_SELECT_CLEAR      = 4'h9;
  localparam logic [3:0] NFB_READY_BUSY_STATUS       = 4'hF;

  // ============================================================
  // Flash command codes used by host software.
  localparam logic [7:0] NFB_CMD_READ    = 8'h00;
  localparam logic [7:0] NFB_CMD_PROGRAM = 8'h80;
  localparam logic [7:0] NFB_CMD_COMMIT  = 8'h10;
  localparam logic [7:0] NFB_CMD_ERASE   = 8'h60;
  localparam logic [7:0] NFB_CMD_CONFIRM = 8'hD0;
  localparam logic [7:0] NFB_CMD_STATUS  = 8'h70;
  localparam logic [7:0] NFB_CMD_IDENT   = 8'h90;
  localparam logic [7:0] NFB_CMD_ABORT   = 8'hFF;

  // ============================================================
  // Reset levels of the held control lines.
  localparam logic NFB_RST_ADDR_LATCH = 1'b0;
  localparam logic NFB_RST_SPARE_N    = 1'b1;
  localparam logic NFB_RST_PROTECT_N  = 1'b1;
  localparam logic NFB_RST_SELECT_N   = 1'b1;

  // Held control lines towards the flash.
  typedef struct packed {
    logic addr_latch;
    logic spare_enable_n;
    logic write_protect_n;
    logic flash_select_out_n;
  } nfb_ctrl_t;

  // Decoded host access.
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [3:0] port;
  } nfb_access_t;

endpackage

/* File: nfb_decode.sv */
// Host access decoder for the NAND flash port bridge.
// Assumes host strobes are synchronous to clk.
`timescale 1ns/1ns
module nfb_decode
  import nfb_pkg::*;
#(
  parameter int ADDR_W = 16,
  parameter logic [ADDR_W-1:0] BASE = '0
) (
  // Host bus
  input  wire logic              host_select_n,
  input  wire logic              host_rd_n,
  input  wire logic              host_wr_n,
  input  wire logic [ADDR_W-1:0] host_addr,
  // Decoded access
  output nfb_access_t            acc
);

  logic hit;

  // ============================================================
  // Address match above base.
  always_comb begin
    hit      = !host_select_n &&
               (host_addr[ADDR_W-1:4] == BASE[ADDR_W-1:4]);
    acc.port = host_addr[3:0];
    acc.rd   = hit && !host_rd_n;
    acc.wr   = hit && !host_wr_n && host_rd_n;
  end

endmodule // nfb_decode

/* File: nfb_flash_model.sv */
// Behavioural flash partner for the port bridge bench.
// Assumes strobes and latches come from the bridge; clk times busy.
`timescale 1ns/1ns
module nfb_flash_model
  import nfb_pkg::*;
#(
  parameter logic [7:0] MFG_ID = 8'h5A, // Arbitrary value.
  parameter logic [7:0] DEV_ID = 8'hC3  // Arbitrary value.
) (
  // Bridge side
  input  wire logic       clk,
  input  wire logic       ale,
  input  wire logic       cle,
  input  wire logic       re_n,
  input  wire logic       we_n,
  input  wire logic       ce_n,
  input  wire logic [7:0] din,
  output logic      [7:0] dout,
  output logic            rb_n
);
  logic [7:0] cmd  = 8'h00;
  logic [7:0] rdn  = 8'h00;
  logic [5:0] busy = 6'h00;
  logic [1:0] la   = 2'b00;
  initial dout = 8'h00;
  assign rb_n = (busy == 6'h00);
  always @(negedge we_n) la = {ale, cle};
  always @(posedge we_n) begin
    if (!ce_n && la == 2'b01) begin
      cmd = din;
      rdn = 8'h00;
      if (din == NFB_CMD_COMMIT || din == NFB_CMD_CONFIRM) busy = 6'h14;
      if (din == NFB_CMD_ABORT) busy = 6'h00;
    end
  end
  always @(posedge clk) if (busy != 6'h00) busy = busy - 6'h01;
  always @(negedge re_n) begin
    case (cmd)
      NFB_CMD_STATUS: dout = {1'b0, rb_n, 6'h00};
      NFB_CMD_IDENT:  dout = rdn[0] ? DEV_ID : MFG_ID;
      default:        dout = rdn;
    endcase
    rdn = rdn + 8'h01;
  end
  // A released bus shows the inverse of its last value.
  always @(posedge re_n) dout = ~dout;
endmodule // nfb_flash_model

/* File: nand_flash_port_bridge_bench.sv */
// Self-checking bench for the port bridge with a flash partner.
// Assumes BASE 0, ADDR_W 16, RB_N 1 and a 250 MHz clock.
`timescale 1ns/1ns
module nand_flash_port_bridge_bench
  import nfb_pkg::*;
;
  localparam logic [7:0] MFG = 8'h5A;
  localparam logic [7:0] DEV = 8'hC3;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        sel_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic [7:0]  wdata = 8'h00, rdata, fio_out, fio_in, got;
  logic        rdata_oe_n, rdy, rdy_oe_n, fio_oe_n, ale, cle;
  logic        re_n, we_n, se_n, wp_n, cs_n;
  logic [0:0]  rb_n;
  nfb_ctrl_t   ec;
  int          miscompares = 0, tests_run = 0, cyc = 0, i;
  always #2 clk = ~clk;
  nfb_bridge dut (.clk(clk), .reset(reset), .host_select_n(sel_n),
    .host_rd_n(rd_n), .host_wr_n(wr_n), .host_addr(addr),
    .host_wdata(wdata), .host_rdata(rdata), .host_rdata_oe_n(rdata_oe_n),
    .ready(rdy), .ready_oe_n(rdy_oe_n), .flash_io_in(fio_in),
    .flash_io_out(fio_out), .flash_io_oe_n(fio_oe_n), .address_latch(ale),
    .command_latch(cle), .read_strobe_n(re_n), .write_strobe_n(we_n),
    .spare_enable_n(se_n), .write_protect_n(wp_n),
    .flash_select_out_n(cs_n), .ready_busy_n(rb_n));
  nfb_flash_model #(.MFG_ID(MFG), .DEV_ID(DEV)) flash (.clk(clk),
    .ale(ale), .cle(cle), .re_n(re_n), .we_n(we_n), .ce_n(cs_n),
    .din(fio_out), .dout(fio_in), .rb_n(rb_n[0]));
  // ============================================================
  // Checks and bus cycles.
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask
  task automatic acc(input logic r, w, s, input logic [15:0] a,
                     input logic [7:0] d);
    logic       hit, rde, wre;
    logic [3:0] p;
    hit = !s && a[15:4] == 12'h000;
    p = a[3:0];
    rde = hit && r;
    wre = hit && w && !r;
    @(posedge clk);
    sel_n <= s;
    rd_n <= !r;
    wr_n <= !w;
    addr <= a;
    wdata <= d;
    @(negedge clk);
    got = rdata;
    chk(cle === (hit && (r || w) && p == 4'h1), "cle");
    chk(re_n === !(rde && p == 4'h0), "read strobe");
    chk(we_n === !(wre && p < 4'h2), "write strobe");
    chk(fio_oe_n === we_n && (we_n === 1'b1 || fio_out === d), "io");
    chk(rdy_oe_n === !(rde && p == 4'hF), "ready drive");
    if (rde && p == 4'hF) chk(rdata === {7'h00, rb_n} && rdy === rb_n[0], "F");
    if (rde && p == 4'h0) chk(rdata === fio_in, "port 0 data");
    if (wre && p >= 4'h2 && p <= 4'h9) case (p[3:1])
      3'd1: ec.addr_latch = !p[0];
      3'd2: ec.spare_enable_n = p[0];
      3'd3: ec.write_protect_n = p[0];
      default: ec.flash_select_out_n = p[0];
    endcase
    @(posedge clk);
    sel_n <= 1'b1;
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    @(negedge clk);
    chk({ale, se_n, wp_n, cs_n} === ec, "held lines");
  endtask
  task automatic wr(input logic [3:0] p, input logic [7:0] d);
    acc(1'b0, 1'b1, 1'b0, {12'h000, p}, d);
  endtask
  task automatic rd(input logic [3:0] p);
    acc(1'b1, 1'b0, 1'b0, {12'h000, p}, 8'h00);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      miscompares++;
      end_sim();
    end
  end
  // ============================================================
  // Main sequence.
  initial begin
    ec = {NFB_RST_ADDR_LATCH, NFB_RST_SPARE_N, NFB_RST_PROTECT_N,
          NFB_RST_SELECT_N};
    void'($urandom(68));
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    chk({ale, se_n, wp_n, cs_n, re_n, we_n, cle} === {ec, 3'b110}, "rst");
    for (i = 0; i < 300; i++) acc(1'($urandom), 1'($urandom),
      $urandom % 4 == 0, {($urandom % 4 == 0) ? 12'($urandom) : 12'h000,
      4'($urandom)}, 8'($urandom));
    wr(4'h8, 8'h00);
    wr(4'h3, 8'h00);
    wr(NFB_FLASH_COMMAND_PORT, NFB_CMD_IDENT);
    rd(4'h0);
    chk(got === MFG, "first id byte");
    rd(4'h0);
    chk(got === DEV, "second id byte");
    wr(4'h1, NFB_CMD_PROGRAM);
    wr(4'h2, 8'h00);
    repeat (2) wr(4'h0, 8'($urandom));
    wr(4'h3, 8'h00);
    repeat (32) wr(4'h0, 8'($urandom));
    wr(4'h1, NFB_CMD_COMMIT);
    rd(4'hF);
    chk(got === 8'h00, "busy after program");
    wr(4'h1, NFB_CMD_ABORT);
    rd(4'hF);
    chk(got === 8'h01, "ready after abort");
    rd(4'h0);
    chk(got === 8'h00, "read mode data");
    wr(4'h1, NFB_CMD_ERASE);
    wr(4'h2, 8'h00);
    repeat (2) wr(4'h0, 8'($urandom));
    wr(4'h3, 8'h00);
    wr(4'h1, NFB_CMD_CONFIRM);
    wr(4'h1, NFB_CMD_STATUS);
    rd(4'h0);
    chk(got === 8'h00, "status busy");
    repeat (25) @(posedge clk);
    rd(4'h0);
    chk(got === 8'h40, "status ready");
    end_sim();
  end
endmodule // nand_flash_port_bridge_bench
